// ===== hw/txpe_handler.sv
// Transmit packet-end handler for a four-segment user bus.
// Assumes user logic on the pclk domain drives the segment signals.
//
// Operation
// - End flag only on a packet's last word
// - End flag read only when valid
// - Error flag read only with valid and end
// - Bad packet marked by error on last word
// - Errored last word replaced by error word
// - Errored packet skips frame check once
// - Four-bit empty count on last word
// - Empty count used only with valid, end
// - Error forces low empty bits to zero
// - Four independent segment signal sets
// - Segment signals sampled only when valid; a non-valid segment's data still passes through to out_data
// - 128-bit payload captured on every valid
// - Start flag only on first transfer
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module txpe_handler
  import txpe_pkg::*;
(
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Segmented user bus in
  input wire logic [TXPE_SEGS-1:0] seg_valid,
  input wire logic [TXPE_SEGS-1:0] seg_start,
  input wire logic [TXPE_SEGS-1:0] seg_end,
  input wire logic [TXPE_SEGS-1:0] seg_err,
  input wire logic [TXPE_SEGS*TXPE_EMPTY_W-1:0] seg_empty,
  input wire logic [TXPE_SEGS*TXPE_DATA_W-1:0] seg_data,
  output logic in_ready,
  // Processed stream out
  output logic out_valid,
  input wire logic out_ready,
  output logic [TXPE_SEGS*TXPE_DATA_W-1:0] out_data,
  output logic [TXPE_SEGS-1:0] out_start,
  output logic [TXPE_SEGS-1:0] out_end,
  output logic [TXPE_SEGS*5-1:0] out_bytes,
  output logic [TXPE_SEGS-1:0] out_fcs_skip
);

  // ==========================================================
  // Per-segment decode
  localparam int W = TXPE_SEGS*TXPE_DATA_W + TXPE_SEGS*8;
  logic [TXPE_SEGS*TXPE_DATA_W-1:0] proc_data;
  logic [TXPE_SEGS-1:0] proc_start;
  logic [TXPE_SEGS-1:0] proc_end;
  logic [TXPE_SEGS*5-1:0] proc_bytes;
  logic [TXPE_SEGS-1:0] proc_skip;
  logic [TXPE_SEGS-1:0] seg_bad;
  logic en_reg;

  always_comb
  begin
    for (int s = 0; s < TXPE_SEGS; s++)
    begin
      logic [3:0] mty;
      logic v_end;
      logic v_err;
      mty = seg_empty[s*TXPE_EMPTY_W +: TXPE_EMPTY_W];
      // Flags count only with valid, and error only with end
      v_end = seg_valid[s] & seg_end[s];
      v_err = v_end & seg_err[s];
      seg_bad[s] = v_err;
      proc_start[s] = seg_valid[s] & seg_start[s];
      proc_end[s] = v_end;
      if (v_err)
        mty = {mty[3], TXPE_EMPTY_LOW_ZERO};
      // Full word for a valid segment unless it is a qualified last word; zero bytes when not valid
      if (v_end)
        proc_bytes[s*5 +: 5] = TXPE_BYTES_C - {1'b0, mty};
      else if (seg_valid[s])
        proc_bytes[s*5 +: 5] = TXPE_BYTES_C;
      else
        proc_bytes[s*5 +: 5] = 5'h00;
      proc_data[s*TXPE_DATA_W +: TXPE_DATA_W] = v_err ? TXPE_ERR_WORD
        : seg_data[s*TXPE_DATA_W +: TXPE_DATA_W];
      proc_skip[s] = v_err;
    end
  end

  // ==========================================================
  // Two-entry buffer so an output stall loses nothing
  logic [W-1:0] buf_mem [0:1];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  logic push;
  logic pop;
  logic [W-1:0] push_word;
  logic [W-1:0] head;

  assign push_word = {proc_data, proc_start, proc_end, proc_skip, proc_bytes};
  // Take a beat only when in_ready promised room, so a held beat is not pushed twice
  assign push = clk_en & en_reg & in_ready & (|seg_valid) & (count_reg != 2'h2);
  // The head leaves the buffer when it moves into the output register
  assign pop = out_load;
  assign head = buf_mem[rd_ptr_reg];

  always_ff @(posedge pclk)
  begin
    if (push)
      buf_mem[wr_ptr_reg] <= push_word;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end
    else if (clk_en)
    begin
      if (push)
        wr_ptr_reg <= ~wr_ptr_reg;
      if (pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  // Output register stage; refilled from the buffer head
  logic out_load;
  logic [1:0] count_next;
  assign out_load = clk_en & (count_reg != 2'h0) & (~out_valid | out_ready);
  assign count_next = count_reg + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_valid <= 1'b0;
      out_data <= '0;
      out_start <= '0;
      out_end <= '0;
      out_fcs_skip <= '0;
      out_bytes <= '0;
    end
    else if (clk_en)
    begin
      if (out_load)
      begin
        out_valid <= 1'b1;
        {out_data, out_start, out_end, out_fcs_skip, out_bytes} <= head;
      end
      else if (out_ready)
        out_valid <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      in_ready <= 1'b0;
    else if (clk_en)
      // Ready next cycle only if the buffer will still have a free slot
      in_ready <= en_reg & (count_next != 2'h2);
  end

  // ==========================================================
  // APB registers: control, packet and error counts, status
  logic [31:0] pkt_cnt_reg;
  logic [31:0] err_cnt_reg;
  logic clr_cnt;
  logic apb_wr;
  logic [2:0] ends_n;
  logic [2:0] errs_n;

  assign apb_wr = psel & penable & pwrite & pready;
  assign clr_cnt = apb_wr & (paddr == TXPE_CTRL_OFF) & pwdata[TXPE_CTRL_CLR_BIT];

  always_comb
  begin
    ends_n = 3'h0;
    errs_n = 3'h0;
    for (int s = 0; s < TXPE_SEGS; s++)
    begin
      ends_n = ends_n + {2'h0, proc_end[s]};
      errs_n = errs_n + {2'h0, seg_bad[s]};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      en_reg <= TXPE_CTRL_RESET[TXPE_CTRL_EN_BIT];
    else if (clk_en && apb_wr && paddr == TXPE_CTRL_OFF)
      en_reg <= pwdata[TXPE_CTRL_EN_BIT];
  end

  // A clear in the same cycle as counting restarts the counts from this beat's ends and errors
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pkt_cnt_reg <= '0;
      err_cnt_reg <= '0;
    end
    else if (clk_en)
    begin
      if (push)
      begin
        pkt_cnt_reg <= (clr_cnt ? 32'h0 : pkt_cnt_reg) + {29'h0, ends_n};
        err_cnt_reg <= (clr_cnt ? 32'h0 : err_cnt_reg) + {29'h0, errs_n};
      end
      else if (clr_cnt)
      begin
        pkt_cnt_reg <= '0;
        err_cnt_reg <= '0;
      end
    end
  end

  // One wait state: answer in the second access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      pready <= psel & penable & ~pready;
      pslverr <= 1'b0;
      prdata <= '0;
      if (psel && penable && !pready)
      begin
        case (paddr)
          TXPE_CTRL_OFF: prdata <= {31'h0, en_reg};
          TXPE_PKT_CNT_OFF: prdata <= pkt_cnt_reg;
          TXPE_ERR_CNT_OFF: prdata <= err_cnt_reg;
          TXPE_STATUS_OFF: prdata <= {29'h0, out_valid, count_reg};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ===== hw/txpe_pkg.sv
// Package for the transmit packet-end handler of the segmented user bus.
// Assumes a single pclk domain; the handler, checker and testbench import it.
package txpe_pkg;
  // ==========================================================
  // Bus geometry
  localparam int TXPE_SEGS = 4;
  localparam int TXPE_DATA_W = 128;
  localparam int TXPE_EMPTY_W = 4;
  localparam int TXPE_BYTES = 16;
  localparam logic [4:0] TXPE_BYTES_C = 5'h10;
  localparam logic [2:0] TXPE_EMPTY_LOW_ZERO = 3'h0;
  // Error control block pattern that replaces the last word
  localparam logic [127:0] TXPE_ERR_WORD = {16{8'hFE}};
  // ==========================================================
  // APB register map
  localparam logic [11:0] TXPE_CTRL_OFF = 12'h000;
  localparam logic [11:0] TXPE_PKT_CNT_OFF = 12'h004;
  localparam logic [11:0] TXPE_ERR_CNT_OFF = 12'h008;
  localparam logic [11:0] TXPE_STATUS_OFF = 12'h00C;
  localparam int TXPE_CTRL_EN_BIT = 0;
  localparam int TXPE_CTRL_CLR_BIT = 1;
  localparam logic [31:0] TXPE_CTRL_RESET = 32'h0000_0001;
endpackage

// ===== testbench/txpe_handler_asserts.sv
// Checker on the handler's APB and output ports.
// Bound into every txpe_handler; one pclk domain.
`timescale 1ns/10ps
`default_nettype none
module txpe_chk
  import txpe_pkg::*;
(
  // Clock, reset, APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Output stream
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [511:0] out_data,
  input wire logic [3:0] out_end,
  input wire logic [19:0] out_bytes,
  input wire logic [3:0] out_fcs_skip
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_apb_wait: assert property (psel && $rose(penable) |=> pready)
    else $error("late pready");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("long pready");
  a_err_ack: assert property (pslverr |-> pready)
    else $error("lone pslverr");
  a_out_held: assert property (out_valid && !out_ready
    |=> out_valid && $stable(out_data)) else $error("beat lost");
  a_err_word: assert property (out_valid && out_fcs_skip[3]
    |-> out_data[511:384] == TXPE_ERR_WORD) else $error("no error word");
  a_skip_end: assert property (out_valid
    |-> (out_fcs_skip & ~out_end) == 4'h0) else $error("skip off end");
  a_err_bytes: assert property (out_valid && out_fcs_skip[3]
    |-> out_bytes[17:15] == 3'h0) else $error("low empty kept");
  a_bytes_top: assert property (out_valid
    |-> out_bytes[4:0] <= 5'h10) else $error("too many bytes");
endmodule
bind txpe_handler txpe_chk u_txpe_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .out_valid, .out_ready, .out_data, .out_end, .out_bytes, .out_fcs_skip);
`default_nettype wire

// ===== testbench/txpe_user_model.sv
// User transmit model: drives one beat, holds it until taken or 20 cycles pass.
// Assumes in_ready from the handler on the same pclk.
`timescale 1ns/10ps
`default_nettype none
module txpe_user_model (
  // Clock and handshake
  input wire logic pclk,
  input wire logic in_ready,
  // Segment signals
  output logic [3:0] seg_valid,
  output logic [3:0] seg_start,
  output logic [3:0] seg_end,
  output logic [3:0] seg_err,
  output logic [15:0] seg_empty,
  output logic [511:0] seg_data
);
  initial
    {seg_valid, seg_start, seg_end, seg_err, seg_empty, seg_data} = '0;
  task automatic send(input logic [3:0] v, s, x, r, input logic [15:0] m,
    input logic [511:0] d, output bit ok);
    @(posedge pclk);
    {seg_valid, seg_start, seg_end, seg_err, seg_empty, seg_data}
      <= {v, s, x, r, m, d};
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++)
    begin
      @(posedge pclk);
      ok = in_ready;
    end
    // Inverted data after release, so a stale word cannot pass for fresh
    seg_valid <= 4'h0;
    seg_data <= ~d;
  endtask
endmodule
`default_nettype wire

// ===== testbench/txpe_handler_test.sv
// Testbench for txpe_handler: APB registers and segment beats.
// Assumes the bound checker and the user model.
`timescale 1ns/10ps
`default_nettype none
module txpe_handler_test;
  import txpe_pkg::*;
  localparam logic [511:0] D = {64{8'h3C}};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, out_ready = 1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, in_ready, out_valid, e;
  logic [3:0] seg_valid, seg_start, seg_end, seg_err, out_end, out_fcs_skip, rs, out_start, rst;
  logic [15:0] seg_empty;
  logic [511:0] seg_data, out_data, rd;
  logic [19:0] out_bytes, rb;
  int bad_count = 0, cmp_count = 0, n;
  bit ok;
  always #2 pclk = ~pclk;
  txpe_handler u_txpe_handler (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .seg_valid, .seg_start, .seg_end, .seg_err,
    .seg_empty, .seg_data, .in_ready, .out_valid, .out_ready, .out_data, .out_start,
    .out_end, .out_bytes, .out_fcs_skip);
  txpe_user_model u_txpe_user_model (.pclk, .in_ready, .seg_valid, .seg_start, .seg_end,
    .seg_err, .seg_empty, .seg_data);
  task automatic chk(input logic [127:0] got, exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("Mismatches %0d of %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic tmo(input int i);
    if (i >= 20)
    begin
      bad_count++;
      wrap_up();
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i = 0;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++i < 20);
    {r, e} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
    tmo(i);
  endtask
  // Stall at least one cycle so out_ready is never written twice at once
  task automatic get(input int stall);
    int i = 0;
    out_ready <= 1'b0;
    repeat (stall) @(posedge pclk);
    out_ready <= 1'b1;
    do @(posedge pclk); while (out_valid !== 1'b1 && ++i < 20);
    {rd, rb, rs, rst} = {out_data, out_bytes, out_fcs_skip, out_start};
    tmo(i);
  endtask
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(0, TXPE_CTRL_OFF, 0);
    chk(r, TXPE_CTRL_RESET);
    apb(0, 12'h010, 0);
    chk({r, e}, 33'h1);
    u_txpe_user_model.send(4'hF, 4'h1, 4'h8, 4'h1, 16'h5000, D, ok);
    get(2);
    chk(ok, 1'b1);
    chk(rd[511:384], D[511:384]);
    chk(rst, 4'h1);
    chk({rs, rb}, {4'h0, 5'h0B, 5'h10, 5'h10, 5'h10});
    u_txpe_user_model.send(4'h8, 4'h8, 4'hA, 4'hA, 16'hF0F0, D, ok);
    get(3);
    chk(rd[511:384], TXPE_ERR_WORD);
    chk(rst, 4'h8);
    chk({rs, rb}, {4'h8, 5'h08, 15'h0});
    u_txpe_user_model.send(4'h1, 4'h1, 4'h1, 4'h0, 16'h0007, D, ok);
    get(1);
    chk({rs, rb}, {4'h0, 15'h0, 5'h09});
    apb(0, TXPE_PKT_CNT_OFF, 0);
    chk(r, 32'h3);
    apb(0, TXPE_ERR_CNT_OFF, 0);
    chk(r, 32'h1);
    apb(1, TXPE_CTRL_OFF, 32'h3);
    apb(0, TXPE_PKT_CNT_OFF, 0);
    chk(r, 32'h0);
    out_ready <= 1'b0;
    for (n = 0; n < 6; n++)
    begin
      u_txpe_user_model.send(4'h1, 4'h1, 4'h1, 4'h0, 16'h0, D, ok);
      if (!ok)
        break;
    end
    chk(ok, 1'b0);
    repeat (n) get(1);
    repeat (3) @(posedge pclk);
    chk(out_valid, 1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire
